// File: logic/burst_counter.sv
// two-bit burst address sequencer
`timescale 1ns/1ps
module burst_counter (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       load,
  input  wire logic       advance,
  input  wire logic       burst_order_select,
  input  wire logic [1:0] startLow,
  output logic      [1:0] burstLow
);
  logic [1:0] start;
  logic [1:0] count;
  wire  [1:0] next_count = load ? burst_sram_pkg::BURST_ZERO
                         : advance ? count + burst_sram_pkg::BURST_STEP : count;
  wire  [1:0] next_start = load ? startLow : start;
  // order select high is linear, low interleaved
  // next_count so the first advance already steps past the loaded word
  assign burstLow = burst_order_select ? start + next_count : start ^ next_count;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= burst_sram_pkg::BURST_ZERO;
      start <= burst_sram_pkg::BURST_ZERO;
    end
    else
    begin
      count <= next_count;
      start <= next_start;
    end
  end
endmodule // burst_counter

// File: logic/burst_sram_pkg.sv
// constants and types shared by the pipelined burst memory port
// Summary of operation
// - data moves two cycles after address capture
// - address, data, control sampled on rising edge
// - read and write follow back to back
// - suspend high freezes every internal register
// - deselect starts nothing, pending transfers finish
// - bus released two cycles after deselect/write
// - burst gives four words from one address
// - order input picks linear or interleaved
// - load low takes address, high advances
// - output enable acts without the clock
// - four (x36) or two (x18) active-low byte write enables
// - 512K x 36 or 1M x 18 array
// - read/write select captured with the load
// - sleep request puts device in low power
// - load while deselected ends the burst
// - byte enables sampled each write cycle, 9-bit bytes
// - suspended edge leaves outputs untouched
package burst_sram_pkg;
  localparam int WIDE_ADDR_BITS   = 19;
  localparam int WIDE_LANES       = 4;
  localparam int NARROW_ADDR_BITS = 20;
  localparam int NARROW_LANES     = 2;
  localparam int BYTE_BITS        = 9;
  localparam int BURST_BITS       = 2;
  localparam int PIPE_DEPTH       = 2;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  typedef enum logic [1:0] {
    OP_IDLE  = 2'h0,
    OP_READ  = 2'h1,
    OP_WRITE = 2'h3
  } op_t;
endpackage

// File: logic/pipelined_burst_sram_port.sv
// synchronous port of the pipelined burst memory
`timescale 1ns/1ps
module pipelined_burst_sram_port #(
  parameter int ADDR_BITS = burst_sram_pkg::WIDE_ADDR_BITS,
  parameter int LANES     = burst_sram_pkg::WIDE_LANES
) (
  input  wire logic                                       ref_clk,
  input  wire logic                                       rst_n,
  input  wire logic                                       suspend_n,
  input  wire logic                                       select_a_n,
  input  wire logic                                       select_b,
  input  wire logic                                       select_c_n,
  input  wire logic                                       advance_or_load,
  input  wire logic                                       readNotWrite,
  input  wire logic                                       burst_order_select,
  input  wire logic [LANES-1:0]                           byte_write_n,
  input  wire logic                                       sleep_request,
  input  wire logic                                       outputEnable_n,
  input  wire logic [ADDR_BITS-1:0]                       word_address,
  input  wire logic [LANES*burst_sram_pkg::BYTE_BITS-1:0] dataIn,
  output logic      [LANES*burst_sram_pkg::BYTE_BITS-1:0] dataOut,
  output logic                                            dataOe,
  output logic                                            sleeping
);
  localparam int W  = LANES*burst_sram_pkg::BYTE_BITS;
  localparam int BB = burst_sram_pkg::BURST_BITS;
  typedef burst_sram_pkg::op_t op_t;

  // suspend_n is active high: high level means suspended
  wire run      = !suspend_n && !sleeping;
  wire selected = !select_a_n && select_b && !select_c_n;
  wire load     = run && !advance_or_load;
  wire advance  = run && advance_or_load;
  wire startOp  = load && selected;
  wire endBurst = load && !selected;

  op_t                 burstOp;
  op_t                 op1;
  op_t                 op2;
  logic [ADDR_BITS-1:0] baseAddr;
  logic [ADDR_BITS-1:0] addr1;
  logic [ADDR_BITS-1:0] addr2;
  logic [LANES-1:0]     lanes1;
  logic [LANES-1:0]     lanes2;
  logic [1:0]           burstLow;
  logic [W-1:0]         arrayRead;
  logic [W-1:0]         readReg;
  logic                 driveReg;

  // new op on load, repeat burst op on advance, idle on deselect
  wire op_t next_burstOp = startOp ? (readNotWrite ? burst_sram_pkg::OP_READ
                                                   : burst_sram_pkg::OP_WRITE)
                         : endBurst ? burst_sram_pkg::OP_IDLE : burstOp;
  wire op_t stage0Op = load ? next_burstOp
                     : advance ? burstOp : burst_sram_pkg::OP_IDLE;
  // external address ignored while advancing
  wire [ADDR_BITS-1:0] stage0Base = startOp ? word_address : baseAddr;
  wire [ADDR_BITS-1:0] stage0Addr = {stage0Base[ADDR_BITS-1:BB], 
                                     startOp ? word_address[BB-1:0] : burstLow};
  // byte enables only matter on writes
  wire [LANES-1:0] stage0Lanes = ~byte_write_n;
  wire writeNow = run && (op2 == burst_sram_pkg::OP_WRITE);
  wire readNow  = run && (op2 == burst_sram_pkg::OP_READ);

  burst_counter u_counter (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .load               (startOp),
    .advance            (advance),
    .burst_order_select (burst_order_select),
    .startLow           (word_address[BB-1:0]),
    .burstLow           (burstLow)
  );

  sram_array #(
    .ADDR_BITS (ADDR_BITS),
    .LANES     (LANES)
  ) u_array (
    .ref_clk   (ref_clk),
    .address   (addr2),
    .writeEn   (writeNow),
    .laneEn    (lanes2),
    .writeData (dataIn),
    .readData  (arrayRead)
  );

  // output enable gates the pins without waiting for a clock edge
  assign dataOe  = driveReg && !outputEnable_n;
  assign dataOut = readReg;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sleeping <= 1'b0;
    else if (!suspend_n)
      sleeping <= sleep_request;
  end

  // every stage holds while suspended, so data stays on the bus
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      burstOp <= burst_sram_pkg::OP_IDLE;
      op1     <= burst_sram_pkg::OP_IDLE;
      op2     <= burst_sram_pkg::OP_IDLE;
      addr1   <= '0;
      addr2   <= '0;
      lanes1  <= '0;
      lanes2  <= '0;
      baseAddr <= '0;
    end
    else if (run)
    begin
      burstOp  <= next_burstOp;
      baseAddr <= stage0Base;
      op1      <= stage0Op;
      addr1    <= stage0Addr;
      lanes1   <= stage0Lanes;
      op2      <= op1;
      addr2    <= addr1;
      lanes2   <= lanes1;
    end
  end

  // read data is registered at the data stage; drive follows it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      readReg  <= '0;
      driveReg <= 1'b0;
    end
    else if (run)
    begin
      readReg  <= readNow ? arrayRead : readReg;
      driveReg <= (op2 == burst_sram_pkg::OP_READ);
    end
  end
endmodule // pipelined_burst_sram_port

// File: logic/sram_array.sv
// word array with per-byte write lanes
`timescale 1ns/1ps
module sram_array #(
  parameter int ADDR_BITS = burst_sram_pkg::WIDE_ADDR_BITS,
  parameter int LANES     = burst_sram_pkg::WIDE_LANES
) (
  input  wire logic                                      ref_clk,
  input  wire logic [ADDR_BITS-1:0]                      address,
  input  wire logic                                      writeEn,
  input  wire logic [LANES-1:0]                          laneEn,
  input  wire logic [LANES*burst_sram_pkg::BYTE_BITS-1:0] writeData,
  output logic      [LANES*burst_sram_pkg::BYTE_BITS-1:0] readData
);
  localparam int BB = burst_sram_pkg::BYTE_BITS;
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : lane
      // one array per lane, so no two processes write the same variable
      logic [BB-1:0] mem [0:(1<<ADDR_BITS)-1];
      assign readData[g*BB +: BB] = mem[address];
      always_ff @(posedge ref_clk)
      begin
        if (writeEn && laneEn[g])
          mem[address] <= writeData[g*BB +: BB];
      end
    end
  endgenerate
endmodule // sram_array

// File: tb/bus_master_model.sv
// far-side master data driver, write data two running edges after load
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic        ref_clk,
  input  wire logic        run,
  input  wire logic        wrGo,
  input  wire logic [35:0] wrWord,
  output logic      [35:0] dataIn
);
  logic [1:0]  live = 2'h0;
  logic [35:0] st1  = 36'h0;
  logic [35:0] st2  = 36'h0;
  always @(posedge ref_clk)
    if (run)
    begin
      live <= {live[0], wrGo};
      st1  <= wrWord;
      st2  <= st1;
    end
  // outside the data slot the bus shows the inverted delayed word, not stale data
  assign dataIn = live[1] ? st2 : ~st2;
endmodule // bus_master_model

// File: tb/pipelined_burst_sram_port_asserts.sv
// concurrent checks on the burst memory port pins
`timescale 1ns/1ps
module pipelined_burst_sram_port_asserts #(
  parameter int LANES = 4
) (
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic                   suspend_n,
  input wire logic                   select_a_n,
  input wire logic                   select_b,
  input wire logic                   select_c_n,
  input wire logic                   advance_or_load,
  input wire logic                   readNotWrite,
  input wire logic                   sleep_request,
  input wire logic                   outputEnable_n,
  input wire logic [LANES*9-1:0]     dataOut,
  input wire logic                   dataOe,
  input wire logic                   sleeping
);
  wire run = !suspend_n && !sleeping;
  wire ld  = run && !advance_or_load;
  wire sel = !select_a_n && select_b && !select_c_n;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rd_lat_a: assert property ((ld && sel && readNotWrite) ##1 run ##1 run |=> dataOe || outputEnable_n)
    else $error("read data missing two cycles after load");
  wr_off_a: assert property ((ld && sel && !readNotWrite) ##1 run ##1 run |=> !dataOe)
    else $error("bus driven in write data slot");
  desel_off_a: assert property ((ld && !sel) ##1 run ##1 run |=> !dataOe)
    else $error("bus driven after deselect");
  oe_off_a: assert property (outputEnable_n |-> !dataOe)
    else $error("bus driven with output enable off");
  susp_hold_a: assert property (suspend_n |=> $stable(dataOut) && $stable(sleeping))
    else $error("outputs moved on suspended edge");
  sleep_st_a: assert property (!suspend_n |=> sleeping == $past(sleep_request))
    else $error("sleep state does not follow request");
  turn_a: assert property ((ld && sel && !readNotWrite) ##1 (ld && sel && readNotWrite) ##1 run ##1 run
    |-> !dataOe ##1 (dataOe || outputEnable_n))
    else $error("write then read not back to back");
  pend_a: assert property ((ld && sel && readNotWrite) ##1 (ld && !sel) ##1 run |=> dataOe || outputEnable_n)
    else $error("pending read dropped by deselect");
endmodule // pipelined_burst_sram_port_asserts

// File: tb/pipelined_burst_sram_port_tb_top.sv
// self-checking bench for the pipelined burst memory port
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb_top;
  logic        ref_clk = 0, rst_n = 0, suspend_n = 1, advance_or_load = 1, readNotWrite = 1;
  logic        burst_order_select = 1, sleep_request = 0, outputEnable_n = 0, wrGo = 0;
  logic        sleeping, dataOe, act = 0, op = 1, ranLast = 0, hold = 0;
  logic [2:0]  sel = 3'h0;
  logic [1:0]  k = 2'h0;
  logic [3:0]  byte_write_n = 4'h0;
  logic [18:0] word_address = 19'h0, base = 19'h0;
  logic [35:0] dataIn, dataOut, wrWord = 36'h0;
  logic [35:0] mem [int];
  logic [35:0] exp [$];
  logic [63:0] seed = 64'h119A1;
  int          err_total = 0, checks = 0;
  always #5 ref_clk = ~ref_clk;
  pipelined_burst_sram_port pipelined_burst_sram_port_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .suspend_n(suspend_n), .select_a_n(sel[0]), .select_b(!sel[1]), .select_c_n(sel[2]),
    .advance_or_load(advance_or_load), .readNotWrite(readNotWrite),
    .burst_order_select(burst_order_select), .byte_write_n(byte_write_n),
    .sleep_request(sleep_request), .outputEnable_n(outputEnable_n), .word_address(word_address),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .sleeping(sleeping));
  bus_master_model bus_master_model_i (.ref_clk(ref_clk), .run(!suspend_n && !sleeping),
    .wrGo(wrGo), .wrWord(wrWord), .dataIn(dataIn));
  function automatic logic [63:0] xs(input logic [63:0] v);
    v ^= v << 13;
    v ^= v >> 7;
    return v ^ (v << 17);
  endfunction
  task automatic cmp(input string n, input logic [35:0] e, input logic [35:0] s);
    checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one bus cycle; the model skips edges the port spends suspended (hold), but still moves on edges lost to sleep
  task automatic cyc(input logic a, r, input logic [2:0] s, input logic [18:0] ad,
    input logic [3:0] m);
    logic [18:0] x;
    @(posedge ref_clk);
    seed = xs(seed);
    if (!hold)
    begin
      if (!a) {act, op, base, k} = {s == 3'h0, r, ad, 2'h0};
      else k = k + 2'h1;
      x = {base[18:2], burst_order_select ? base[1:0] + k : base[1:0] ^ k};
      if (act && op) exp.push_back(mem[x]);
      for (int i = 0; i < 4; i++)
        if (act && !op && !m[i]) mem[x][i*9+:9] = seed[i*9+:9];
    end
    {advance_or_load, readNotWrite, sel, byte_write_n} <= {a, r, s, m};
    suspend_n <= hold;
    word_address <= a ? seed[62:44] : ad;
    wrGo <= act && !op;
    wrWord <= seed[35:0];
  endtask
  always @(posedge ref_clk) ranLast <= !suspend_n && !sleeping;
  always @(negedge ref_clk)
    if (rst_n && ranLast && dataOe) cmp("dataOut", exp.pop_front(), dataOut);
  initial
  begin
    repeat (12) @(posedge ref_clk);
    {rst_n, suspend_n} <= 2'b10;
    for (int i = 0; i < 8; i++) cyc(0, 0, 0, 19'(i), 4'h0);
    cyc(0, 0, 0, 1, 4'hA);
    cyc(0, 1, 0, 5, 0);
    cyc(0, 0, 0, 6, 0);
    cyc(0, 1, 0, 1, 0);
    cyc(0, 0, 0, 7, 4'h3);
    cyc(0, 1, 0, 0, 0);
    cyc(0, 0, 0, 2, 4'h5);
    repeat (3) cyc(1, 1, 0, 0, 4'h9);
    for (int o = 0; o < 2; o++)
    begin
      cyc(0, 1, 3'h1, 0, 0);
      // order changes only while deselected, never under a running burst
      burst_order_select <= o[0];
      cyc(0, 1, 0, 5, 0);
      repeat (3) cyc(1, 0, 0, 0, 0);
    end
    for (int j = 0; j < 3; j++)
    begin
      cyc(0, 1, 0, 3, 0);
      cyc(0, 1, 3'h1 << j, 0, 0);
      cyc(1, 1, 0, 0, 0);
    end
    cyc(0, 1, 0, 2, 0);
    hold = 1;
    repeat (2) cyc(0, 0, 0, 3, 0);
    hold = 0;
    cyc(1, 1, 0, 0, 0);
    sleep_request <= 1;
    repeat (3) cyc(0, 1, 3'h1, 0, 0);
    sleep_request <= 0;
    outputEnable_n <= 1;
    repeat (2) cyc(0, 1, 3'h4, 0, 0);
    outputEnable_n <= 0;
    cyc(0, 1, 0, 4, 0);
    repeat (4) cyc(0, 1, 3'h2, 0, 0);
    cmp("pending reads", 36'h0, 36'(exp.size()));
    stop_test();
  end
  initial
  begin
    #5us;
    err_total++;
    stop_test();
  end
endmodule // pipelined_burst_sram_port_tb_top
bind pipelined_burst_sram_port pipelined_burst_sram_port_asserts #(.LANES(LANES)) chk_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .suspend_n(suspend_n), .select_a_n(select_a_n),
  .select_b(select_b), .select_c_n(select_c_n), .advance_or_load(advance_or_load),
  .readNotWrite(readNotWrite), .sleep_request(sleep_request), .outputEnable_n(outputEnable_n),
  .dataOut(dataOut), .dataOe(dataOe), .sleeping(sleeping));
